// ===== rtl/mbl_host_end.sv
/*
 * Host end: turns user read/write requests into strobe sequences for the
 * selected bus mode, with latch phase, access wait and early strobe end.
 * Assumes the device end shares clk and the mode given on cfg_mode.
 */
`timescale 1ns/1ps
`default_nettype none

module mbl_host_end (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire mbl_pkg::mbl_mode_t   cfg_mode,
    input  wire logic                 req,
    input  wire logic                 req_we,
    input  wire logic [19:0]          req_addr,
    input  wire logic [1:0]           req_be,
    input  wire logic [15:0]          req_wdata,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output logic [15:0]               rsp_rdata,
    mbl_bus_if.host                   bus
);
    import mbl_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE   = 2'b00,
        H_LATCH  = 2'b01,
        H_STROBE = 2'b11,
        H_RECOV  = 2'b10
    } mbl_hstate_t;

    mbl_hstate_t      state_reg;
    mbl_cnt_t         cnt_reg;
    mbl_mode_t        mode_reg;
    logic             we_reg;
    logic [19:0]      addr_reg;
    logic [1:0]       be_reg;
    logic [DW-1:0]    wdata_reg;
    logic             burst_ok_reg;
    logic             strobe;
    logic             rd;
    logic             wr;
    logic             a0;
    logic             c0_next;
    logic             c1_next;
    logic             c2_next;
    logic             pd3_next;
    logic             hold_data;
    logic [DW-1:0]    ad_addr;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= cfg_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= H_IDLE;
            cnt_reg      <= '0;
            we_reg       <= 1'b0;
            addr_reg     <= '0;
            be_reg       <= '0;
            wdata_reg    <= ZERO_W;
            burst_ok_reg <= 1'b0;
            req_ready    <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp_rdata    <= ZERO_W;
        end else begin
            rsp_valid <= 1'b0;
            cnt_reg   <= cnt_reg + mbl_cnt_t'(1);
            case (state_reg)
                H_IDLE: begin
                    req_ready <= 1'b1;
                    cnt_reg   <= '0;
                    if (req && req_ready) begin
                        req_ready <= 1'b0;
                        we_reg    <= req_we;
                        addr_reg  <= req_addr;
                        be_reg    <= req_be;
                        wdata_reg <= req_wdata;
                        // Same 16-byte line: only the low bits step
                        if (mode_reg == MBL_MODE_BURST && !req_we && burst_ok_reg
                            && req_addr[19:4] == addr_reg[19:4]) begin
                            state_reg <= H_STROBE;
                        end else begin
                            state_reg <= H_LATCH;
                        end
                    end
                end
                H_LATCH: begin
                    if (cnt_reg == mbl_cnt_t'(ALE_CYC)) begin
                        cnt_reg   <= '0;
                        state_reg <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    if (cnt_reg == mbl_cnt_t'(ACCESS_CYC - 1)) begin
                        cnt_reg      <= '0;
                        state_reg    <= H_RECOV;
                        burst_ok_reg <= (mode_reg == MBL_MODE_BURST) && !we_reg;
                        if (!we_reg) begin
                            rsp_rdata <= lane_swap(mode_reg, is_mux(mode_reg)
                                         ? bus.addr_data_pins : bus.data_port_pins);
                        end
                    end
                end
                H_RECOV: begin
                    rsp_valid <= 1'b1;
                    state_reg <= H_IDLE;
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin encoding per mode
    always_comb begin
        strobe    = (state_reg == H_STROBE);
        rd        = strobe && !we_reg;
        wr        = strobe && we_reg;
        a0        = (be_reg == 2'b10);
        hold_data = we_reg && (state_reg == H_STROBE || state_reg == H_RECOV);
        ad_addr   = (mode_reg == MBL_MODE_BURST) ? addr_reg[19:4] : {addr_reg[15:1], a0};
        c0_next   = 1'b1;
        c1_next   = 1'b1;
        c2_next   = 1'b1;
        pd3_next  = 1'b1;
        case (mode_reg)
            MBL_MODE_WR_BHE: begin
                c0_next = !wr;
                c1_next = !rd;
                c2_next = !be_reg[1];
            end
            MBL_MODE_WRL_WRH, MBL_MODE_BURST, MBL_MODE_OE_WR: begin
                c0_next  = !(wr && be_reg[0]);
                pd3_next = !(wr && be_reg[1]);
                c1_next  = !rd;
            end
            MBL_MODE_SIZ: begin
                c0_next = !wr;
                c1_next = !strobe;
                c2_next = (be_reg != 2'b11);
            end
            MBL_MODE_UDS: begin
                c0_next = !wr;
                c1_next = !(strobe && be_reg[1]);
                c2_next = !(strobe && be_reg[0]);
            end
            default: begin
                c0_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus.ctl_pin_0            <= 1'b1;
            bus.ctl_pin_1            <= 1'b1;
            bus.ctl_pin_2            <= 1'b1;
            bus.port_d_bit3          <= 1'b1;
            bus.address_latch_strobe <= 1'b0;
            bus.addr_hi              <= '0;
            bus.addr_low3            <= '0;
            bus.ad_host_out          <= ZERO_W;
            bus.ad_host_oe_n         <= 1'b1;
            bus.dp_host_out          <= ZERO_W;
            bus.dp_host_oe_n         <= 1'b1;
        end else begin
            bus.ctl_pin_0            <= c0_next;
            bus.ctl_pin_1            <= c1_next;
            bus.ctl_pin_2            <= c2_next;
            bus.port_d_bit3          <= pd3_next;
            bus.address_latch_strobe <= (state_reg == H_LATCH)
                                        && (cnt_reg < mbl_cnt_t'(ALE_CYC));
            bus.addr_hi              <= addr_reg[19:16];
            bus.addr_low3            <= addr_reg[3:1];
            if (is_mux(mode_reg)) begin
                bus.ad_host_out  <= (state_reg == H_LATCH) ? ad_addr
                                    : lane_swap(mode_reg, wdata_reg);
                bus.ad_host_oe_n <= !((state_reg == H_LATCH) || hold_data);
                bus.dp_host_oe_n <= 1'b1;
            end else begin
                bus.ad_host_out  <= ad_addr;
                bus.ad_host_oe_n <= (state_reg == H_IDLE);
                bus.dp_host_out  <= lane_swap(mode_reg, wdata_reg);
                bus.dp_host_oe_n <= !hold_data;
            end
        end
    end

endmodule : mbl_host_end

`default_nettype wire

// ===== rtl/mbl_pkg.sv
/*
 * Shared definitions for the byte-lane host bus port: bus modes, widths,
 * timing counts and the lane placement helpers used by both ends.
 * Assumes a single 10 MHz clock shared by both ends.
 */
package mbl_pkg;

    localparam int DW       = 16;
    localparam int BW       = 8;
    localparam int HI_W     = 4;
    localparam int LOW3_W   = 3;
    localparam int WA_W     = 19;
    localparam int MEM_AW   = 8;
    localparam int MEM_DEPTH = 256;
    localparam int CNT_W    = 4;

    localparam logic [10:0]   SEL_BASE = 11'h000;
    localparam logic [DW-1:0] PULL_UP  = 16'hFFFF;
    localparam logic [DW-1:0] ZERO_W   = 16'h0000;

    // Access window the host must respect
    localparam int CLK_PERIOD_NS  = 100;
    localparam int ACCESS_TIME_NS = 600;
    localparam int ACCESS_CYC     = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALE_CYC        = 2;

    typedef logic [CNT_W-1:0] mbl_cnt_t;

    typedef enum logic [2:0] {
        MBL_MODE_WR_BHE  = 3'h0,
        MBL_MODE_WRL_WRH = 3'h1,
        MBL_MODE_BURST   = 3'h2,
        MBL_MODE_SIZ     = 3'h3,
        MBL_MODE_UDS     = 3'h4,
        MBL_MODE_OE_WR   = 3'h5
    } mbl_mode_t;

    function automatic logic is_mux(input mbl_mode_t m);
        is_mux = (m == MBL_MODE_WR_BHE) || (m == MBL_MODE_WRL_WRH) || (m == MBL_MODE_BURST);
    endfunction : is_mux

    // Even byte on the upper lane for size/strobe style hosts
    function automatic logic big_endian(input mbl_mode_t m);
        big_endian = (m == MBL_MODE_SIZ) || (m == MBL_MODE_UDS);
    endfunction : big_endian

    // Converts between {odd, even} and the lane order on the pins
    function automatic logic [DW-1:0] lane_swap(input mbl_mode_t m, input logic [DW-1:0] w);
        lane_swap = big_endian(m) ? {w[BW-1:0], w[DW-1:BW]} : w;
    endfunction : lane_swap

endpackage : mbl_pkg

// ===== rtl/mbl_bus_if.sv
/*
 * Pin-level bus between the host and the device end.
 * Assumes both ends run on the same clock; shared pins resolve here
 * with a pull-up level when nobody drives.
 */
`timescale 1ns/1ps
`default_nettype none

interface mbl_bus_if;
    import mbl_pkg::*;

    logic              ctl_pin_0;
    logic              ctl_pin_1;
    logic              ctl_pin_2;
    logic              port_d_bit3;
    logic              address_latch_strobe;
    logic [HI_W-1:0]   addr_hi;
    logic [LOW3_W-1:0] addr_low3;
    logic [DW-1:0]     ad_host_out;
    logic              ad_host_oe_n;
    logic [DW-1:0]     ad_dev_out;
    logic              ad_dev_oe_n;
    logic [DW-1:0]     dp_host_out;
    logic              dp_host_oe_n;
    logic [DW-1:0]     dp_dev_out;
    logic              dp_dev_oe_n;
    logic [DW-1:0]     addr_data_pins;
    logic [DW-1:0]     data_port_pins;

    // Data port: upper byte is port G, lower byte is port F
    assign addr_data_pins = !ad_host_oe_n ? ad_host_out : (!ad_dev_oe_n ? ad_dev_out : PULL_UP);
    assign data_port_pins = !dp_host_oe_n ? dp_host_out : (!dp_dev_oe_n ? dp_dev_out : PULL_UP);

    modport host (
        output ctl_pin_0, ctl_pin_1, ctl_pin_2, port_d_bit3, address_latch_strobe,
        output addr_hi, addr_low3, ad_host_out, ad_host_oe_n, dp_host_out, dp_host_oe_n,
        input  addr_data_pins, data_port_pins
    );

    modport dev (
        input  ctl_pin_0, ctl_pin_1, ctl_pin_2, port_d_bit3, address_latch_strobe,
        input  addr_hi, addr_low3, addr_data_pins, data_port_pins,
        output ad_dev_out, ad_dev_oe_n, dp_dev_out, dp_dev_oe_n
    );

endinterface : mbl_bus_if

`default_nettype wire

// ===== rtl/mbl_dev_end.sv
/*
 * Device end of the byte-lane host bus port: decodes host strobes into
 * byte-lane reads and writes of a small local memory, for six bus modes.
 * Assumes pins arrive unsynchronised; mode is strapped and caught in reset.
 */
`timescale 1ns/1ps
`default_nettype none

module mbl_dev_end (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire mbl_pkg::mbl_mode_t   cfg_mode,
    input  wire logic                 cfg_use_latch,
    output logic                      access_active,
    output logic                      write_done,
    mbl_bus_if.dev                    bus
);
    import mbl_pkg::*;

    localparam int SYNC_W = 5 + HI_W + LOW3_W + DW + DW;

    mbl_mode_t          mode_reg;
    logic               use_latch_reg;
    logic [SYNC_W-1:0]  sync1_reg;
    logic [SYNC_W-1:0]  sync2_reg;
    logic               s_c0;
    logic               s_c1;
    logic               s_c2;
    logic               s_pd3;
    logic               s_ale;
    logic [HI_W-1:0]    s_hi;
    logic [LOW3_W-1:0]  s_low3;
    logic [DW-1:0]      s_ad;
    logic [DW-1:0]      s_dp;
    logic [DW-1:0]      lat_ad_reg;
    logic [HI_W-1:0]    lat_hi_reg;
    logic               mux;
    logic [WA_W-1:0]    wa;
    logic               a0;
    logic               sel;
    logic [3:0]         dec;
    logic               dec_rd;
    logic               dec_wr;
    logic               dec_odd;
    logic               dec_even;
    logic [DW-1:0]      lane_word;
    logic               wr_prev_reg;
    logic [1:0]         wen_reg;
    logic [BW-1:0]      wr_odd_reg;
    logic [BW-1:0]      wr_even_reg;
    logic [MEM_AW-1:0]  widx_reg;
    logic               wsel_reg;
    logic               commit;
    logic [BW-1:0]      mem_odd  [MEM_DEPTH];
    logic [BW-1:0]      mem_even [MEM_DEPTH];

    // Returns {read, write, odd lane, even lane}; pins are active low
    function automatic logic [3:0] lane_decode(
        input mbl_mode_t m,
        input logic      c0,
        input logic      c1,
        input logic      c2,
        input logic      pd3,
        input logic      addr0
    );
        logic act;
        act = 1'b0;
        case (m)
            MBL_MODE_WR_BHE: begin
                lane_decode = {!c1, !c0, !c2, !addr0};
            end
            MBL_MODE_WRL_WRH, MBL_MODE_OE_WR: begin
                lane_decode = {!c1, !c0 || !pd3, !pd3, !c0};
            end
            MBL_MODE_BURST: begin
                lane_decode = {!c1 || !c2, !c0 || !pd3, !pd3, !c0};
            end
            MBL_MODE_SIZ: begin
                act         = !c1;
                lane_decode = {act && c0, act && !c0, !c2 || addr0, !addr0};
            end
            MBL_MODE_UDS: begin
                act         = !c1 || !c2;
                lane_decode = {act && c0, act && !c0, !c1, !c2};
            end
            default: begin
                lane_decode = 4'h0;
            end
        endcase
    endfunction : lane_decode

    ////////////////////////////////////////////////////////////////////////
    // Configuration, caught while reset is held
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg      <= cfg_mode;
            use_latch_reg <= cfg_use_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end else begin
            sync1_reg <= {bus.ctl_pin_0, bus.ctl_pin_1, bus.ctl_pin_2, bus.port_d_bit3,
                          bus.address_latch_strobe, bus.addr_hi, bus.addr_low3,
                          bus.addr_data_pins, bus.data_port_pins};
            sync2_reg <= sync1_reg;
        end
    end

    assign {s_c0, s_c1, s_c2, s_pd3, s_ale, s_hi, s_low3, s_ad, s_dp} = sync2_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address latch and decode
    assign mux = is_mux(mode_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            lat_ad_reg <= ZERO_W;
            lat_hi_reg <= '0;
        end else if (s_ale || (!mux && !use_latch_reg)) begin
            lat_ad_reg <= s_ad;
            lat_hi_reg <= s_hi;
        end
    end

    always_comb begin
        if (mode_reg == MBL_MODE_BURST) begin
            wa = {lat_ad_reg, s_low3};
            a0 = 1'b0;
        end else begin
            wa = {lat_hi_reg, lat_ad_reg[DW-1:1]};
            a0 = lat_ad_reg[0];
        end
        sel = (wa[WA_W-1:MEM_AW] == SEL_BASE);
    end

    assign dec       = lane_decode(mode_reg, s_c0, s_c1, s_c2, s_pd3, a0);
    assign dec_rd    = dec[3];
    assign dec_wr    = dec[2];
    assign dec_odd   = dec[1];
    assign dec_even  = dec[0];
    assign lane_word = lane_swap(mode_reg, mux ? s_ad : s_dp);

    ////////////////////////////////////////////////////////////////////////
    // Writes commit on the trailing edge of the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_prev_reg <= 1'b0;
            wen_reg     <= 2'b00;
            wr_odd_reg  <= '0;
            wr_even_reg <= '0;
            widx_reg    <= '0;
            wsel_reg    <= 1'b0;
        end else begin
            wr_prev_reg <= dec_wr;
            if (dec_wr) begin
                wen_reg     <= {dec_odd, dec_even};
                wr_odd_reg  <= lane_word[DW-1:BW];
                wr_even_reg <= lane_word[BW-1:0];
                widx_reg    <= wa[MEM_AW-1:0];
                wsel_reg    <= sel;
            end
        end
    end

    assign commit = wr_prev_reg && !dec_wr && wsel_reg;

    always_ff @(posedge clk) begin
        if (commit && wen_reg[1]) begin
            mem_odd[widx_reg] <= wr_odd_reg;
        end
        if (commit && wen_reg[0]) begin
            mem_even[widx_reg] <= wr_even_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, refreshed every cycle so burst data tracks the low bits
    always_ff @(posedge clk) begin
        if (rst) begin
            bus.ad_dev_out  <= ZERO_W;
            bus.dp_dev_out  <= ZERO_W;
            bus.ad_dev_oe_n <= 1'b1;
            bus.dp_dev_oe_n <= 1'b1;
        end else begin
            bus.ad_dev_out  <= lane_swap(mode_reg, {mem_odd[wa[MEM_AW-1:0]],
                                                    mem_even[wa[MEM_AW-1:0]]});
            bus.dp_dev_out  <= lane_swap(mode_reg, {mem_odd[wa[MEM_AW-1:0]],
                                                    mem_even[wa[MEM_AW-1:0]]});
            bus.ad_dev_oe_n <= !(dec_rd && sel && mux);
            bus.dp_dev_oe_n <= !(dec_rd && sel && !mux);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User-side status
    always_ff @(posedge clk) begin
        if (rst) begin
            access_active <= 1'b0;
            write_done    <= 1'b0;
        end else begin
            access_active <= sel && (dec_rd || dec_wr);
            write_done    <= commit;
        end
    end

endmodule : mbl_dev_end

`default_nettype wire

// ===== verif/mbl_bus_chk.sv
/* Assertions on the pins between host end and device end.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module mbl_bus_chk (
    input wire logic               clk,
    input wire logic               rst,
    input wire mbl_pkg::mbl_mode_t cfg_mode,
    input wire logic               ctl_pin_0,
    input wire logic               ctl_pin_1,
    input wire logic               ctl_pin_2,
    input wire logic               address_latch_strobe,
    input wire logic               ad_host_oe_n,
    input wire logic               ad_dev_oe_n,
    input wire logic               dp_host_oe_n,
    input wire logic               dp_dev_oe_n,
    input wire logic [15:0]        ad_host_out,
    input wire logic [15:0]        dp_host_out
);
    import mbl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_ad_read;
        !ad_dev_oe_n |-> !$past(ctl_pin_1, 2) || !$past(ctl_pin_1, 3) || !$past(ctl_pin_1, 4);
    endproperty
    a_ad_read: assert property (p_ad_read) else $error("ad driven without read");
    property p_ad_mux;
        !ad_dev_oe_n |-> cfg_mode <= MBL_MODE_BURST;
    endproperty
    a_ad_mux: assert property (p_ad_mux) else $error("ad driven in non-mux mode");
    property p_dp_read;
        !dp_dev_oe_n |-> cfg_mode >= MBL_MODE_SIZ
            && ($past(ctl_pin_0, 2) || $past(ctl_pin_0, 3) || $past(ctl_pin_0, 4));
    endproperty
    a_dp_read: assert property (p_dp_read) else $error("data port driven wrongly");
    property p_mux_hold;
        $rose(ctl_pin_0) && cfg_mode <= MBL_MODE_BURST |-> !ad_host_oe_n && $stable(ad_host_out);
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("write data not held");
    property p_uds_hold;
        cfg_mode == MBL_MODE_UDS && !$past(ctl_pin_0) && ($rose(ctl_pin_1) || $rose(ctl_pin_2))
            |-> !dp_host_oe_n && $stable(dp_host_out);
    endproperty
    a_uds_hold: assert property (p_uds_hold) else $error("enables not early");
    property p_oe_hold;
        cfg_mode == MBL_MODE_OE_WR && $rose(ctl_pin_0) |-> !dp_host_oe_n && $stable(dp_host_out);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("low write data not held");
    property p_strobe_len;
        $fell(ctl_pin_1) |-> (!ctl_pin_1)[*6] ##1 ctl_pin_1;
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
    property p_ale_len;
        $rose(address_latch_strobe) |-> address_latch_strobe[*2] ##1 !address_latch_strobe;
    endproperty
    a_ale_len: assert property (p_ale_len) else $error("latch pulse length wrong");
    property p_ale_ad;
        address_latch_strobe && cfg_mode <= MBL_MODE_BURST |-> !ad_host_oe_n;
    endproperty
    a_ale_ad: assert property (p_ale_ad) else $error("latch without address");
    property p_siz_stable;
        cfg_mode == MBL_MODE_SIZ && !ctl_pin_1 && !$past(ctl_pin_1)
            |-> $stable(ctl_pin_0) && $stable(ctl_pin_2);
    endproperty
    a_siz_stable: assert property (p_siz_stable) else $error("size moved in strobe");
endmodule : mbl_bus_chk
`default_nettype wire

// ===== verif/mcu_byte_lane_bus_port_test.sv
/* Bench: both ends joined by the bus interface, every mode run
   against a word model. Assumes the package, interface and checker. */
`timescale 1ns/1ps
`default_nettype none
module mcu_byte_lane_bus_port_test;
    import mbl_pkg::*;
    logic        clk, rst, use_latch, req, req_we, req_ready, rsp_valid, act, write_done;
    mbl_mode_t   mode;
    logic [19:0] req_addr;
    logic [1:0]  req_be, be;
    logic [15:0] req_wdata, rsp_rdata, wire_w, rd, wd;
    logic [15:0] mem_m [16];
    logic        act_seen;
    logic [16:0] line;
    int          fail_count, checks_done, wd_cnt, n_wr, a, k;

    mbl_bus_if mbl_bus_if_inst ();
    mbl_host_end mbl_host_end_inst (.clk(clk), .rst(rst), .cfg_mode(mode), .req(req),
        .req_we(req_we), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .bus(mbl_bus_if_inst));
    mbl_dev_end mbl_dev_end_inst (.clk(clk), .rst(rst), .cfg_mode(mode),
        .cfg_use_latch(use_latch), .access_active(act), .write_done(write_done),
        .bus(mbl_bus_if_inst));
    mbl_bus_chk mbl_bus_chk_inst (.clk(clk), .rst(rst), .cfg_mode(mode),
        .ctl_pin_0(mbl_bus_if_inst.ctl_pin_0), .ctl_pin_1(mbl_bus_if_inst.ctl_pin_1),
        .ctl_pin_2(mbl_bus_if_inst.ctl_pin_2),
        .address_latch_strobe(mbl_bus_if_inst.address_latch_strobe),
        .ad_host_oe_n(mbl_bus_if_inst.ad_host_oe_n), .ad_dev_oe_n(mbl_bus_if_inst.ad_dev_oe_n),
        .dp_host_oe_n(mbl_bus_if_inst.dp_host_oe_n), .dp_dev_oe_n(mbl_bus_if_inst.dp_dev_oe_n),
        .ad_host_out(mbl_bus_if_inst.ad_host_out), .dp_host_out(mbl_bus_if_inst.dp_host_out));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Last word the host drove on its data lanes
    always @(posedge clk) begin
        if (write_done === 1'b1)
            wd_cnt++;
        if (act === 1'b1)
            act_seen = 1'b1;
        if (mbl_bus_if_inst.dp_host_oe_n === 1'b0)
            wire_w = mbl_bus_if_inst.data_port_pins;
        else if (mode <= MBL_MODE_BURST && mbl_bus_if_inst.ad_host_oe_n === 1'b0)
            wire_w = mbl_bus_if_inst.addr_data_pins;
    end

    function automatic logic [15:0] lanes(input mbl_mode_t m, input logic [15:0] w);
        return (m == MBL_MODE_SIZ || m == MBL_MODE_UDS) ? {w[7:0], w[15:8]} : w;
    endfunction : lanes

    function automatic logic [15:0] merge(input logic [15:0] o, w, input logic [1:0] b);
        return {b[1] ? w[15:8] : o[15:8], b[0] ? w[7:0] : o[7:0]};
    endfunction : merge

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic check(input logic [15:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic xfer(input logic we, input logic [19:0] ad, input logic [1:0] b,
                        input logic [15:0] w);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 60);
        req <= 1'b1;
        req_we <= we;
        req_addr <= ad;
        req_be <= b;
        req_wdata <= w;
        @(posedge clk);
        req <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (k == 1)
                act_seen = 1'b0;
        end while (rsp_valid !== 1'b1 && k < 60);
        if (n >= 60 || k >= 60) begin
            fail_count++;
            $display("wrong value at %0t: no answer", $time);
            final_report();
        end else begin
            rd = rsp_rdata;
            if (mode == MBL_MODE_BURST && !we && line == {1'b1, ad[19:4]})
                check(16'(k), 16'(ACCESS_CYC + 2), "burst latency");
            else
                check(16'(k), 16'(ALE_CYC + ACCESS_CYC + 3), "latency");
            check(16'(act_seen), 16'(ad[19:9] == SEL_BASE), "active");
            line = {mode == MBL_MODE_BURST && !we, ad[19:4]};
        end
    endtask : xfer

    initial begin
        rst = 1'b1;
        req = 1'b0;
        req_we = 1'b0;
        req_addr = 20'h0_0000;
        req_be = 2'b00;
        req_wdata = 16'h0000;
        mode = MBL_MODE_WR_BHE;
        use_latch = 1'b0;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(69));
        for (int m = 0; m < 6; m++) begin
            mode <= mbl_mode_t'(m);
            use_latch <= 1'($urandom_range(1, 0));
            rst <= 1'b1;
            wd_cnt = 0;
            n_wr = 0;
            repeat (10) @(posedge clk);
            rst <= 1'b0;
            for (int i = 0; i < 26; i++) begin
                wd = 16'($urandom());
                be = i < 16 ? 2'b11 : 2'($urandom_range(3, 1));
                a = i < 16 ? i : $urandom_range(15, 0);
                xfer(1'b1, {15'h0000, 4'(a), 1'b0}, be, wd);
                mem_m[a] = merge(mem_m[a], wd, be);
                n_wr++;
                if (be == 2'b11)
                    check(wire_w, lanes(mode, wd), "lanes");
            end
            for (int i = 0; i < 16; i++) begin
                xfer(1'b0, {15'h0000, 4'(i), 1'b0}, 2'b11, 16'h0000);
                check(rd, mem_m[i], "read");
            end
            xfer(1'b0, 20'h0_0200, 2'b11, 16'h0000);
            check(rd, 16'hFFFF, "outside");
            repeat (8) @(posedge clk);
            check(16'(wd_cnt), 16'(n_wr), "writes");
            $display("mode %0d done", m);
        end
        final_report();
    end
endmodule : mcu_byte_lane_bus_port_test
`default_nettype wire
